// ### core/sdtx_pkg.sv
// Purpose: shared constants and types for the transmit mode control block
// Assumes: 10 MHz system clock, 32-bit register bus
// Notes:   offsets are byte addresses

package sdtx_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RECOVERY_NS   = 10000;
  localparam int unsigned RECOVERY_CYC  = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_FEAT_MASK = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 4'h4;

  localparam int unsigned NUM_FEAT = 8;
  localparam logic [NUM_FEAT-1:0] FEAT_MASK_RST = 8'h00;
  localparam int unsigned FEAT_EDH      = 0;
  localparam int unsigned FEAT_VPID     = 1;
  localparam int unsigned FEAT_ANC_CSUM = 2;
  localparam int unsigned FEAT_ANC_INS  = 3;
  localparam int unsigned FEAT_LINE_CRC = 4;
  localparam int unsigned FEAT_LINE_NUM = 5;
  localparam int unsigned FEAT_TRS_INS  = 6;
  localparam int unsigned FEAT_REMAP    = 7;

  // status word field positions
  localparam int unsigned ST_RUN_BIT     = 0;
  localparam int unsigned ST_EXTRACT_BIT = 1;
  localparam int unsigned ST_HSDE_BIT    = 2;
  localparam int unsigned ST_WIDE_BIT    = 3;
  localparam int unsigned ST_SD_BIT      = 4;
  localparam int unsigned ST_ASI_BIT     = 5;
  localparam int unsigned ST_THRU_BIT    = 6;
  localparam int unsigned ST_SCRAM_BIT   = 7;
  localparam int unsigned ST_JTAG_BIT    = 8;
  localparam int unsigned ST_FEAT_LSB    = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned NUM_CTRL = 9;

  typedef struct packed {
    logic test_mode;
    logic rate_sd;
    logic ancillary_blank_n_n;
    logic ioproc_en;
    logic bypass_n;
    logic asi_sel;
    logic bus_wide;
    logic sync_style;
    logic timing_src;
  } sdtx_ctrl_s;

  typedef enum logic [1:0] {
    ST_RECOVER,
    ST_RUN,
    ST_JTAG
  } sdtx_state_e;

endpackage

// ### core/sdtx_sync.sv
// Purpose: two-stage synchroniser bank for static control pins
// Assumes: one clock, active-low asynchronous reset
// Notes:   first stage feeds only the second stage

`timescale 1ns/1ns

module sdtx_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= i_async[g];
        sync_q[g] <= meta_q[g];
      end
    end
  end

  assign o_sync = sync_q;

endmodule

// ### core/sdtx_mode_ctrl.sv
// Purpose: mode and configuration control of a serial video transmitter
// Assumes: control pins static, synchronised here; AXI4-Lite register access
// Notes:   all outputs registered; functional outputs idle until recovery ends or scan mode is left
// Summary of operation
// RL1: timing source low selects external strobes, style chosen by sync style.
// RL2: timing source high selects embedded timing words, sync style ignored.
// RL3: external timing with sync style low means H, V, F inputs.
// RL4: external timing with sync style high means HSYNC, VSYNC, DE inputs.
// RL5: bus width chooses 10-bit single or 20-bit luma plus chroma input.
// RL6: in 10-bit mode the chroma half is ignored and left undriven.
// RL7: rate select low gives HD rates only, high gives SD only.
// RL8: ASI select high encodes ASI, in SD operation only.
// RL9: ASI select low means no ASI encoding.
// RL10: controller must set SD and bypass before choosing ASI.
// RL11: bypass low gives data-through without ASI, ASI mode with it.
// RL12: bypass low skips scrambling and disables every processing feature.
// RL13: bypass high scrambles and performs processing.
// RL14: processing enable high turns on all eight processing features; here EDH is enabled only in SD, line CRC and line number only in HD.
// RL15: with processing enabled, mask bits turn off single features.
// RL16: processing enable low disables all features whatever the mask.
// RL17: test mode high is boundary scan, low is normal host mode.
// RL18: normal mode reset defaults all blocks and floats all pins.
// RL19: normal mode waits 10 us after reset release before running.
// RL20: scan mode reset defaults blocks and holds test sequence reset.
// RL21: blanking input low replaces ancillary data with blanking levels.
// RL22: blanking input high passes ancillary data unchanged.
// RL23: control pins are synchronised to the clock before use.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.

`timescale 1ns/1ns

module sdtx_mode_ctrl #(
  parameter int unsigned RECOVERY_CYCLES = sdtx_pkg::RECOVERY_CYC
) (
  input  wire logic                          I_CLOCK,
  input  wire logic                          I_RST_B,
  input  wire logic                          I_TIMING_SOURCE_SELECT,
  input  wire logic                          I_SYNC_STYLE_SELECT,
  input  wire logic                          I_BUS_WIDTH_SELECT,
  input  wire logic                          I_ASI_MODE_SELECT,
  input  wire logic                          I_CODING_BYPASS_N,
  input  wire logic                          I_IO_PROCESSING_ENABLE,
  input  wire logic                          I_ANCILLARY_BLANK_N,
  input  wire logic                          I_RATE_SELECT,
  input  wire logic                          I_TEST_MODE_SELECT,
  input  wire logic [sdtx_pkg::ADDR_W-1:0]   I_AWADDR,
  input  wire logic                          I_AWVALID,
  output logic                               O_AWREADY,
  input  wire logic [31:0]                   I_WDATA,
  input  wire logic [3:0]                    I_WSTRB,
  input  wire logic                          I_WVALID,
  output logic                               O_WREADY,
  output logic [1:0]                         O_BRESP,
  output logic                               O_BVALID,
  input  wire logic                          I_BREADY,
  input  wire logic [sdtx_pkg::ADDR_W-1:0]   I_ARADDR,
  input  wire logic                          I_ARVALID,
  output logic                               O_ARREADY,
  output logic [31:0]                        O_RDATA,
  output logic [1:0]                         O_RRESP,
  output logic                               O_RVALID,
  input  wire logic                          I_RREADY,
  output logic                               O_RUN,
  output logic                               O_PIN_OE,
  output logic                               O_JTAG_SEQ_HOLD,
  output logic                               O_TIMING_EXTRACT,
  output logic                               O_EXT_HVF,
  output logic                               O_EXT_HSDE,
  output logic                               O_BUS_WIDE,
  output logic                               O_CHROMA_IN_EN,
  output logic                               O_RATE_SD,
  output logic                               O_ASI_ENCODE,
  output logic                               O_DATA_THROUGH,
  output logic                               O_SCRAMBLE_EN,
  output logic [sdtx_pkg::NUM_FEAT-1:0]      O_FEATURE_EN,
  output logic                               O_ANCILLARY_BLANK_N
);

  localparam int unsigned CW = $clog2(RECOVERY_CYCLES + 1);

  // reset release through two flops
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  sdtx_pkg::sdtx_ctrl_s ctrl_raw;
  sdtx_pkg::sdtx_ctrl_s ctrl;
  assign ctrl_raw = '{test_mode:   I_TEST_MODE_SELECT,
                      rate_sd:     I_RATE_SELECT,
                      ancillary_blank_n_n: I_ANCILLARY_BLANK_N,
                      ioproc_en:   I_IO_PROCESSING_ENABLE,
                      bypass_n:    I_CODING_BYPASS_N,
                      asi_sel:     I_ASI_MODE_SELECT,
                      bus_wide:    I_BUS_WIDTH_SELECT,
                      sync_style:  I_SYNC_STYLE_SELECT,
                      timing_src:  I_TIMING_SOURCE_SELECT};

  sdtx_sync #(
    .WIDTH (sdtx_pkg::NUM_CTRL)
  ) u_sync (
    .i_clk   (I_CLOCK),
    .i_rst_n (rst_n),
    .i_async (ctrl_raw),
    .o_sync  (ctrl)  // RL23
  );

  // state
  sdtx_pkg::sdtx_state_e         st_q, st_d;
  logic [CW-1:0]                 cnt_q, cnt_d;
  logic [sdtx_pkg::NUM_FEAT-1:0] mask_q, mask_d;
  logic                          run;
  logic [sdtx_pkg::NUM_FEAT-1:0] feat_ok;
  logic                          aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [sdtx_pkg::ADDR_W-1:0]   awaddr_q, awaddr_d;
  logic [31:0]                   wdata_q, wdata_d;
  logic [3:0]                    wstrb_q, wstrb_d;
  logic                          awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]                    bresp_d, rresp_d;
  logic [31:0]                   rdata_d, status;
  logic                          pin_oe_d, hold_d, extract_d, hvf_d, hsde_d, wide_d, chroma_d;
  logic                          sd_d, asi_d, thru_d, scram_d, blank_d;
  logic [sdtx_pkg::NUM_FEAT-1:0] feat_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    hold_d = 1'b0;
    case (st_q)
      sdtx_pkg::ST_RECOVER: begin
        if (ctrl.test_mode) begin  // RL17
          st_d = sdtx_pkg::ST_JTAG;  // RL20
        end else if (cnt_q >= CW'(RECOVERY_CYCLES - 1)) begin
          st_d = sdtx_pkg::ST_RUN;  // RL19
        end else begin
          cnt_d = CW'(cnt_q + 1'b1);
        end
      end
      sdtx_pkg::ST_RUN: begin
        if (ctrl.test_mode) begin
          st_d = sdtx_pkg::ST_JTAG;
        end
      end
      sdtx_pkg::ST_JTAG: begin
        if (!ctrl.test_mode) begin
          st_d = sdtx_pkg::ST_RUN;
        end
      end
      default: begin
        st_d = sdtx_pkg::ST_RECOVER;
      end
    endcase
  end

  assign run = (st_q == sdtx_pkg::ST_RUN);

  // features that exist at the selected rate
  always_comb begin
    feat_ok = '1;
    feat_ok[sdtx_pkg::FEAT_EDH]      = ctrl.rate_sd;
    feat_ok[sdtx_pkg::FEAT_LINE_CRC] = !ctrl.rate_sd;
    feat_ok[sdtx_pkg::FEAT_LINE_NUM] = !ctrl.rate_sd;
  end

  always_comb begin
    pin_oe_d  = run;  // RL18
    extract_d = run && ctrl.timing_src;  // RL2
    hvf_d     = run && !ctrl.timing_src && !ctrl.sync_style;  // RL1 RL3
    hsde_d    = run && !ctrl.timing_src && ctrl.sync_style;  // RL4
    wide_d    = run && ctrl.bus_wide;  // RL5
    chroma_d  = run && ctrl.bus_wide && !(ctrl.asi_sel && !ctrl.bypass_n);  // RL6
    sd_d      = run && ctrl.rate_sd;  // RL7
    asi_d     = run && ctrl.asi_sel && !ctrl.bypass_n && ctrl.rate_sd;  // RL8 RL9 RL10
    thru_d    = run && !ctrl.bypass_n && !ctrl.asi_sel;  // RL11
    scram_d   = run && ctrl.bypass_n;  // RL12 RL13
    blank_d   = run && !ctrl.ancillary_blank_n_n;  // RL21 RL22
    if (run && ctrl.bypass_n && ctrl.ioproc_en) begin
      feat_d = feat_ok & ~mask_q;  // RL14 RL15
    end else begin
      feat_d = '0;  // RL12 RL16
    end
  end

  always_comb begin
    status = '0;
    status[sdtx_pkg::ST_RUN_BIT]     = O_RUN;
    status[sdtx_pkg::ST_EXTRACT_BIT] = O_TIMING_EXTRACT;
    status[sdtx_pkg::ST_HSDE_BIT]    = O_EXT_HSDE;
    status[sdtx_pkg::ST_WIDE_BIT]    = O_BUS_WIDE;
    status[sdtx_pkg::ST_SD_BIT]      = O_RATE_SD;
    status[sdtx_pkg::ST_ASI_BIT]     = O_ASI_ENCODE;
    status[sdtx_pkg::ST_THRU_BIT]    = O_DATA_THROUGH;
    status[sdtx_pkg::ST_SCRAM_BIT]   = O_SCRAMBLE_EN;
    status[sdtx_pkg::ST_JTAG_BIT]    = (st_q == sdtx_pkg::ST_JTAG);
    status[sdtx_pkg::ST_FEAT_LSB +: sdtx_pkg::NUM_FEAT] = O_FEATURE_EN;
  end

  // register bus slave
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = O_BVALID;
    bresp_d   = O_BRESP;
    mask_d    = mask_q;
    rvalid_d  = O_RVALID;
    rdata_d   = O_RDATA;
    rresp_d   = O_RRESP;
    if (I_AWVALID && O_AWREADY) begin
      aw_held_d = 1'b1;
      awaddr_d  = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      w_held_d = 1'b1;
      wdata_d  = I_WDATA;
      wstrb_d  = I_WSTRB;
    end
    if (O_BVALID && I_BREADY) begin
      bvalid_d = 1'b0;
    end
    if (aw_held_q && w_held_q && !O_BVALID) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = sdtx_pkg::RESP_OKAY;
      if (awaddr_q == sdtx_pkg::OFS_FEAT_MASK) begin
        if (wstrb_q[0]) begin
          mask_d = wdata_q[sdtx_pkg::NUM_FEAT-1:0];  // RL15
        end
      end else if (awaddr_q != sdtx_pkg::OFS_STATUS) begin
        bresp_d = sdtx_pkg::RESP_SLVERR;
      end
    end
    if (O_RVALID && I_RREADY) begin
      rvalid_d = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      rvalid_d = 1'b1;
      rresp_d  = sdtx_pkg::RESP_OKAY;
      rdata_d  = '0;
      case (I_ARADDR)
        sdtx_pkg::OFS_FEAT_MASK: rdata_d[sdtx_pkg::NUM_FEAT-1:0] = mask_q;
        sdtx_pkg::OFS_STATUS:    rdata_d = status;
        default:                 rresp_d = sdtx_pkg::RESP_SLVERR;
      endcase
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      st_q             <= sdtx_pkg::ST_RECOVER;
      cnt_q            <= '0;
      mask_q           <= sdtx_pkg::FEAT_MASK_RST;
      aw_held_q        <= 1'b0;
      w_held_q         <= 1'b0;
      awaddr_q         <= '0;
      wdata_q          <= '0;
      wstrb_q          <= '0;
      O_AWREADY        <= 1'b0;
      O_WREADY         <= 1'b0;
      O_BVALID         <= 1'b0;
      O_BRESP          <= sdtx_pkg::RESP_OKAY;
      O_ARREADY        <= 1'b0;
      O_RVALID         <= 1'b0;
      O_RDATA          <= '0;
      O_RRESP          <= sdtx_pkg::RESP_OKAY;
      O_RUN            <= 1'b0;
      O_PIN_OE         <= 1'b0;
      O_JTAG_SEQ_HOLD  <= 1'b1;  // RL20
      O_TIMING_EXTRACT <= 1'b0;
      O_EXT_HVF        <= 1'b0;
      O_EXT_HSDE       <= 1'b0;
      O_BUS_WIDE       <= 1'b0;
      O_CHROMA_IN_EN   <= 1'b0;
      O_RATE_SD        <= 1'b0;
      O_ASI_ENCODE     <= 1'b0;
      O_DATA_THROUGH   <= 1'b0;
      O_SCRAMBLE_EN    <= 1'b0;
      O_FEATURE_EN     <= '0;
      O_ANCILLARY_BLANK_N      <= 1'b0;
    end else begin
      st_q             <= st_d;
      cnt_q            <= cnt_d;
      mask_q           <= mask_d;
      aw_held_q        <= aw_held_d;
      w_held_q         <= w_held_d;
      awaddr_q         <= awaddr_d;
      wdata_q          <= wdata_d;
      wstrb_q          <= wstrb_d;
      O_AWREADY        <= awready_d;
      O_WREADY         <= wready_d;
      O_BVALID         <= bvalid_d;
      O_BRESP          <= bresp_d;
      O_ARREADY        <= arready_d;
      O_RVALID         <= rvalid_d;
      O_RDATA          <= rdata_d;
      O_RRESP          <= rresp_d;
      O_RUN            <= run;
      O_PIN_OE         <= pin_oe_d;
      O_JTAG_SEQ_HOLD  <= hold_d;
      O_TIMING_EXTRACT <= extract_d;
      O_EXT_HVF        <= hvf_d;
      O_EXT_HSDE       <= hsde_d;
      O_BUS_WIDE       <= wide_d;
      O_CHROMA_IN_EN   <= chroma_d;
      O_RATE_SD        <= sd_d;
      O_ASI_ENCODE     <= asi_d;
      O_DATA_THROUGH   <= thru_d;
      O_SCRAMBLE_EN    <= scram_d;
      O_FEATURE_EN     <= feat_d;
      O_ANCILLARY_BLANK_N      <= blank_d;
    end
  end

  // checks
  localparam int REC_MAX = 110;

  property p_extract;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (run && ctrl.timing_src) |=> (O_TIMING_EXTRACT && !O_EXT_HVF && !O_EXT_HSDE);
  endproperty
  a_extract: assert property (p_extract) else $error("embedded timing not selected");  // RL2

  property p_hvf;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (run && !ctrl.timing_src && !ctrl.sync_style) |=> (O_EXT_HVF && !O_TIMING_EXTRACT);
  endproperty
  a_hvf: assert property (p_hvf) else $error("hvf strobes not selected");  // RL3

  property p_hsde;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (run && !ctrl.timing_src && ctrl.sync_style) |=> (O_EXT_HSDE && !O_EXT_HVF);
  endproperty
  a_hsde: assert property (p_hsde) else $error("hsync de strobes not selected");  // RL4

  property p_chroma;
    @(posedge I_CLOCK) disable iff (!rst_n)
      !ctrl.bus_wide |=> !O_CHROMA_IN_EN;
  endproperty
  a_chroma: assert property (p_chroma) else $error("chroma used in 10-bit mode");  // RL6

  property p_asi;
    @(posedge I_CLOCK) disable iff (!rst_n)
      O_ASI_ENCODE |-> (O_RATE_SD && !O_SCRAMBLE_EN && !O_DATA_THROUGH);
  endproperty
  a_asi: assert property (p_asi) else $error("asi encoding outside sd bypass");  // RL8

  property p_bypass;
    @(posedge I_CLOCK) disable iff (!rst_n)
      !ctrl.bypass_n |=> (O_FEATURE_EN == '0 && !O_SCRAMBLE_EN);
  endproperty
  a_bypass: assert property (p_bypass) else $error("processing active in bypass");  // RL12

  property p_ioproc_off;
    @(posedge I_CLOCK) disable iff (!rst_n)
      !ctrl.ioproc_en |=> (O_FEATURE_EN == '0);
  endproperty
  a_ioproc_off: assert property (p_ioproc_off) else $error("feature on while processing disabled");  // RL16

  property p_mask;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (run && ctrl.bypass_n && ctrl.ioproc_en && !mask_q[sdtx_pkg::FEAT_TRS_INS])
        |=> O_FEATURE_EN[sdtx_pkg::FEAT_TRS_INS];
  endproperty
  a_mask: assert property (p_mask) else $error("unmasked feature not enabled");  // RL14

  sequence s_recovering;
    (st_q == sdtx_pkg::ST_RECOVER) && !ctrl.test_mode && (cnt_q == '0);
  endsequence
  sequence s_running;
    st_q == sdtx_pkg::ST_RUN;
  endsequence
  property p_recover;
    @(posedge I_CLOCK) disable iff (!rst_n || ctrl.test_mode)
      s_recovering |-> (!O_PIN_OE throughout (##[1:REC_MAX] s_running));
  endproperty
  a_recover: assert property (p_recover) else $error("recovery wait wrong");  // RL19

  property p_blank;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (run && !ctrl.ancillary_blank_n_n) |=> O_ANCILLARY_BLANK_N;
  endproperty
  a_blank: assert property (p_blank) else $error("ancillary blanking not applied");  // RL21

endmodule

// ### testbench/sdtx_strap_model.sv
// Purpose: upstream control logic and board straps driving the mode pins
// Assumes: requests come from the bench, one clock
// Notes:   delays the ASI pin until SD rate and bypass are on the pins

`timescale 1ns/1ns

module sdtx_strap_model (
  input  wire logic                 i_clk,
  input  wire sdtx_pkg::sdtx_ctrl_s i_req,
  output sdtx_pkg::sdtx_ctrl_s      o_pins
);
  sdtx_pkg::sdtx_ctrl_s pins_q;
  sdtx_pkg::sdtx_ctrl_s pins_d;

  always_comb begin
    pins_d = i_req;
    // hold ASI off until the pins already show SD and bypass
    if (i_req.asi_sel && !(pins_q.rate_sd && !pins_q.bypass_n)) begin
      pins_d.asi_sel = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    pins_q <= pins_d;
  end

  assign o_pins = pins_q;
endmodule

// ### testbench/sdtx_mode_ctrl_tb.sv
// Purpose: self-checking bench for the transmit mode control block
// Assumes: short recovery count, pins driven through the strap model
// Notes:   reset and recovery checks first, then table rows, register and scan mode cases

`timescale 1ns/1ns

module sdtx_mode_ctrl_tb;
  localparam int unsigned RECOV = 5;
  logic                 clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [3:0]           awaddr, araddr;
  logic [31:0]          wdata, rdata, rd;
  logic [1:0]           bresp, rresp, rsp;
  logic                 run, pin_oe, seq_hold, extract, hvf, hsde, wide, chroma;
  logic                 sd, asi, thru, scram, blank;
  logic [7:0]           feat_en;
  logic [9:0]           got;
  logic [3:0]           wstrb;
  sdtx_pkg::sdtx_ctrl_s req, pins;
  int                   num_errors, comparisons, cyc, n;
  // pins: test,sd,blank_n,ioproc,bypass_n,asi,wide,style,timing
  logic [8:0] cfg_rows [5] = '{9'h075, 9'h0B0, 9'h066, 9'h0ED, 9'h053};
  // extract,hvf,hsde,wide,chroma,sd,asi,thru,scram,blank
  logic [9:0] exp_rows [5] = '{10'h262, 10'h113, 10'h0E4, 10'h258, 10'h202};
  logic [7:0] feat_rows [5] = '{8'hFE, 8'hCF, 8'h00, 8'h00, 8'h00};

  sdtx_strap_model u_strap (.i_clk(clk), .i_req(req), .o_pins(pins));

  sdtx_mode_ctrl #(.RECOVERY_CYCLES(RECOV)) u_dut (
    .I_CLOCK(clk), .I_RST_B(rst_n),
    .I_TIMING_SOURCE_SELECT(pins.timing_src), .I_SYNC_STYLE_SELECT(pins.sync_style),
    .I_BUS_WIDTH_SELECT(pins.bus_wide), .I_ASI_MODE_SELECT(pins.asi_sel),
    .I_CODING_BYPASS_N(pins.bypass_n), .I_IO_PROCESSING_ENABLE(pins.ioproc_en),
    .I_ANCILLARY_BLANK_N(pins.ancillary_blank_n_n), .I_RATE_SELECT(pins.rate_sd),
    .I_TEST_MODE_SELECT(pins.test_mode),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_RUN(run), .O_PIN_OE(pin_oe), .O_JTAG_SEQ_HOLD(seq_hold),
    .O_TIMING_EXTRACT(extract), .O_EXT_HVF(hvf), .O_EXT_HSDE(hsde), .O_BUS_WIDE(wide),
    .O_CHROMA_IN_EN(chroma), .O_RATE_SD(sd), .O_ASI_ENCODE(asi), .O_DATA_THROUGH(thru),
    .O_SCRAMBLE_EN(scram), .O_FEATURE_EN(feat_en), .O_ANCILLARY_BLANK_N(blank)
  );

  always #50 clk = ~clk;

  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // pin change reaches outputs after model, sync and output flops
  task automatic settle();
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge clk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge clk);
      ha = arvalid & arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = cfg_rows[0];
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    num_errors = 0;
    comparisons = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("seq_hold_in_reset", 1, seq_hold);
    chk("pin_oe_in_reset", 0, pin_oe);
    chk("run_in_reset", 0, run);
    @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    while (run !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("recovery_wait", 1, (n >= RECOV + 2) && (n <= RECOV + 6));
    chk("pin_oe_running", 1, pin_oe);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      req <= cfg_rows[i];
      settle();
      got = {extract, hvf, hsde, wide, chroma, sd, asi, thru, scram, blank};
      chk("modes", exp_rows[i], got);
      chk("features", feat_rows[i], feat_en);
    end
    @(posedge clk);
    req <= cfg_rows[0];
    settle();
    axw(sdtx_pkg::OFS_FEAT_MASK, 32'h0000_0081, rsp);
    chk("mask_wr_resp", sdtx_pkg::RESP_OKAY, rsp);
    axr(sdtx_pkg::OFS_FEAT_MASK, rd, rsp);
    chk("mask_readback", 32'h0000_0081, rd);
    @(negedge clk);
    chk("masked_features", 8'h7E, feat_en);
    axr(sdtx_pkg::OFS_STATUS, rd, rsp);
    chk("status_word", 32'h007E_008B, rd);
    axw(sdtx_pkg::OFS_STATUS, 32'h0000_FFFF, rsp);
    chk("status_wr_resp", sdtx_pkg::RESP_OKAY, rsp);
    axw(4'h8, 32'h0000_00FF, rsp);
    chk("unmapped_wr_resp", sdtx_pkg::RESP_SLVERR, rsp);
    axr(4'h8, rd, rsp);
    chk("unmapped_rd_resp", sdtx_pkg::RESP_SLVERR, rsp);
    chk("unmapped_rd_data", 32'h0000_0000, rd);
    // mask byte strobe off: write answered but mask untouched
    wstrb <= 4'hE;
    axw(sdtx_pkg::OFS_FEAT_MASK, 32'h0000_00FF, rsp);
    wstrb <= 4'hF;
    chk("strobe_off_resp", sdtx_pkg::RESP_OKAY, rsp);
    axr(sdtx_pkg::OFS_FEAT_MASK, rd, rsp);
    chk("mask_kept", 32'h0000_0081, rd);
    @(posedge clk);
    req <= cfg_rows[0] | 9'h100;
    settle();
    chk("run_scan", 0, run);
    chk("pin_oe_scan", 0, pin_oe);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    chk("seq_hold_scan_reset", 1, seq_hold);
    chk("features_scan_reset", 0, feat_en);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    chk("seq_hold_released", 0, seq_hold);
    chk("run_still_scan", 0, run);
    @(posedge clk);
    req <= cfg_rows[0];
    settle();
    chk("run_after_scan", 1, run);
    chk("mask_default", 8'hFE, feat_en);
    summarize();
  end
endmodule
